//--- src/gpdr_cfg.svh
// What this block does
// - Port 1 bits 25 and 24 make pins 1.1 and 1.0 outputs when one, inputs when zero.
// - Port 1 bits 17 and 16 drive pins 1.1 and 1.0 while those pins are outputs.
// - Port 1 bits 1 and 0 are read-only levels of pins 1.1 and 1.0, written as zero.
// - Port 2 bits 30, 29, 28, 25, 24 make pins 2.6, 2.5, 2.4, 2.1, 2.0 outputs.
// - Port 2 bits 22, 21, 17, 16 drive pins 2.6, 2.5, 2.1, 2.0; 2.4 has no output bit.
// - Port 2 bits 6, 5, 4, 1, 0 are read-only pin levels, written as zero.
// - Pin 2.5 set as output opens the diagnostic write path to the high-voltage pins.
// - Pin 2.4 as input reads back a high-voltage pin under the three-bit select field.
// - Each register is 32 bits wide, upper bits reset to zero, input bits follow the pins except port 2 bit 4 during readback.
`ifndef GPDR_CFG_SVH
`define GPDR_CFG_SVH

`define GPDR_P1_ADDR   32'hffff0d30
`define GPDR_P2_ADDR   32'hffff0d40
`define GPDR_RD_IDLE   32'h0000_0000
`define GPDR_P1_RSV    32'hfcfc_fffc
`define GPDR_P2_RSV    32'h8c9c_ff8c
`define GPDR_DIR_RST   1'b0
`define GPDR_DOUT_RST  1'b0
`define GPDR_HVSEL_OFF 3'h0

`define GPDR_P1_DIR0   24
`define GPDR_P1_DIR1   25
`define GPDR_P1_DOUT0  16
`define GPDR_P1_DOUT1  17
`define GPDR_P1_DIN0   0
`define GPDR_P1_DIN1   1

`define GPDR_P2_DIR0   24
`define GPDR_P2_DIR1   25
`define GPDR_P2_DIR4   28
`define GPDR_P2_DIR5   29
`define GPDR_P2_DIR6   30
`define GPDR_P2_DOUT0  16
`define GPDR_P2_DOUT1  17
`define GPDR_P2_DOUT5  21
`define GPDR_P2_DOUT6  22
`define GPDR_P2_DIN0   0
`define GPDR_P2_DIN1   1
`define GPDR_P2_DIN4   4
`define GPDR_P2_DIN5   5
`define GPDR_P2_DIN6   6

`define GPDR_P1_PINS   2
`define GPDR_P2_PINS   5
`define GPDR_P2_IDX4   2
`define GPDR_P2_IDX5   3
`define GPDR_SYNC_W    8
`define GPDR_SYNC_HV   7

`endif

//--- src/gpdr_pkg.sv
`include "gpdr_cfg.svh"

package gpdr_pkg;

   typedef struct packed {
      logic [`GPDR_P1_PINS-1:0] dir;
      logic [`GPDR_P1_PINS-1:0] dout;
   } gpdr_p1_t;

   typedef struct packed {
      logic [`GPDR_P2_PINS-1:0] dir;
      logic [`GPDR_P2_PINS-1:0] dout;
   } gpdr_p2_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } gpdr_bus_t;

   typedef enum logic [1:0] {
      GPDR_SEL_NONE,
      GPDR_SEL_P1,
      GPDR_SEL_P2
   } gpdr_sel_t;

endpackage : gpdr_pkg

//--- src/gpdr_port_data.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpdr_cfg.svh"

module gpdr_port_data
   import gpdr_pkg::*;
(
   // clock and reset
   input  wire logic                     clock_i,
   input  wire logic                     rst_n_i,
   // register port
   input  wire logic [31:0]              addr_i,
   input  wire logic [31:0]              wdata_i,
   input  wire logic                     wr_i,
   input  wire logic                     rd_i,
   output logic      [31:0]              rdata_o,
   // port 1 pins
   input  wire logic [`GPDR_P1_PINS-1:0] p1_pin_i,
   output logic      [`GPDR_P1_PINS-1:0] p1_pin_o,
   output logic      [`GPDR_P1_PINS-1:0] p1_pin_oe_o,
   // port 2 pins: 2.0 2.1 2.4 2.5 2.6
   input  wire logic [`GPDR_P2_PINS-1:0] p2_pin_i,
   output logic      [`GPDR_P2_PINS-1:0] p2_pin_o,
   output logic      [`GPDR_P2_PINS-1:0] p2_pin_oe_o,
   // high-voltage diagnostics
   input  wire logic [2:0]               hv_cfg_sel_i,
   input  wire logic                     hv_readback_i,
   output logic                          hv_diag_wr_en_o,
   output logic                          hv_diag_wr_data_o,
   output logic                          hv_readback_en_o,
   output logic      [2:0]               hv_readback_sel_o
);

   localparam int P1_DIR_POS  [`GPDR_P1_PINS] = '{`GPDR_P1_DIR0, `GPDR_P1_DIR1};
   localparam int P1_DOUT_POS [`GPDR_P1_PINS] = '{`GPDR_P1_DOUT0, `GPDR_P1_DOUT1};
   localparam int P1_DIN_POS  [`GPDR_P1_PINS] = '{`GPDR_P1_DIN0, `GPDR_P1_DIN1};
   localparam int P2_DIR_POS  [`GPDR_P2_PINS] = '{`GPDR_P2_DIR0, `GPDR_P2_DIR1,
      `GPDR_P2_DIR4, `GPDR_P2_DIR5, `GPDR_P2_DIR6};
   localparam int P2_DOUT_POS [`GPDR_P2_PINS] = '{`GPDR_P2_DOUT0, `GPDR_P2_DOUT1,
      `GPDR_P2_DOUT0, `GPDR_P2_DOUT5, `GPDR_P2_DOUT6};
   localparam int P2_DIN_POS  [`GPDR_P2_PINS] = '{`GPDR_P2_DIN0, `GPDR_P2_DIN1,
      `GPDR_P2_DIN4, `GPDR_P2_DIN5, `GPDR_P2_DIN6};

   gpdr_bus_t                  bus;
   gpdr_p1_t                   p1;
   gpdr_p1_t                   next_p1;
   gpdr_p2_t                   p2;
   gpdr_p2_t                   next_p2;
   logic [31:0]                rdata;
   logic [31:0]                next_rdata;
   logic [2:0]                 hv_sel;
   logic [2:0]                 next_hv_sel;
   logic [`GPDR_SYNC_W-1:0]    sync_raw;
   logic [`GPDR_SYNC_W-1:0]    sync_lvl;
   logic [`GPDR_P1_PINS-1:0]   p1_din;
   logic [`GPDR_P2_PINS-1:0]   p2_din;
   logic                       hv_active;

   // address decode, shared by write and read paths
   function automatic gpdr_sel_t gpdr_decode(input logic [31:0] addr);
      gpdr_sel_t sel;
      sel = GPDR_SEL_NONE;
      if (addr == `GPDR_P1_ADDR) begin
         sel = GPDR_SEL_P1;
      end else if (addr == `GPDR_P2_ADDR) begin
         sel = GPDR_SEL_P2;
      end
      return sel;
   endfunction : gpdr_decode

   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // pin levels and the readback line cross into the clock domain
   assign sync_raw = {hv_readback_i, p2_pin_i, p1_pin_i};

   gpdr_sync #(
      .WIDTH (`GPDR_SYNC_W)
   ) u_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i (sync_raw),
      .sync_o  (sync_lvl)
   );

   // readback routes the selected high-voltage pin into the 2.4 input bit
   assign hv_active = !p2.dir[`GPDR_P2_IDX4] && (hv_cfg_sel_i != `GPDR_HVSEL_OFF);

   always_comb begin
      p1_din = sync_lvl[`GPDR_P1_PINS-1:0];
      p2_din = sync_lvl[`GPDR_P1_PINS +: `GPDR_P2_PINS];
      if (hv_active) begin
         p2_din[`GPDR_P2_IDX4] = sync_lvl[`GPDR_SYNC_HV];
      end
   end

   // register write path
   always_comb begin
      next_p1 = p1;
      next_p2 = p2;
      if (bus.wr && gpdr_decode(bus.addr) == GPDR_SEL_P1) begin
         for (int i = 0; i < `GPDR_P1_PINS; i++) begin
            next_p1.dir[i]  = bus.wdata[P1_DIR_POS[i]];
            next_p1.dout[i] = bus.wdata[P1_DOUT_POS[i]];
         end
      end
      if (bus.wr && gpdr_decode(bus.addr) == GPDR_SEL_P2) begin
         for (int i = 0; i < `GPDR_P2_PINS; i++) begin
            next_p2.dir[i]  = bus.wdata[P2_DIR_POS[i]];
            next_p2.dout[i] = bus.wdata[P2_DOUT_POS[i]];
         end
      end
      next_p2.dout[`GPDR_P2_IDX4] = `GPDR_DOUT_RST;
   end

   // register read path, data one cycle after the strobe, zero otherwise
   always_comb begin
      next_rdata = `GPDR_RD_IDLE;
      if (bus.rd) begin
         case (gpdr_decode(bus.addr))
            GPDR_SEL_P1: begin
               for (int i = 0; i < `GPDR_P1_PINS; i++) begin
                  next_rdata[P1_DIR_POS[i]]  = p1.dir[i];
                  next_rdata[P1_DOUT_POS[i]] = p1.dout[i];
                  next_rdata[P1_DIN_POS[i]]  = p1_din[i];
               end
            end
            GPDR_SEL_P2: begin
               for (int i = 0; i < `GPDR_P2_PINS; i++) begin
                  next_rdata[P2_DIR_POS[i]] = p2.dir[i];
                  if (i != `GPDR_P2_IDX4) begin
                     next_rdata[P2_DOUT_POS[i]] = p2.dout[i];
                  end
                  next_rdata[P2_DIN_POS[i]] = p2_din[i];
               end
            end
            default: begin
               next_rdata = `GPDR_RD_IDLE;
            end
         endcase
      end
   end

   // readback selection follows the field only while 2.4 is an input
   always_comb begin
      next_hv_sel = `GPDR_HVSEL_OFF;
      if (!next_p2.dir[`GPDR_P2_IDX4]) begin
         next_hv_sel = hv_cfg_sel_i;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p1     <= '{dir: {`GPDR_P1_PINS{`GPDR_DIR_RST}}, dout: {`GPDR_P1_PINS{`GPDR_DOUT_RST}}};
         p2     <= '{dir: {`GPDR_P2_PINS{`GPDR_DIR_RST}}, dout: {`GPDR_P2_PINS{`GPDR_DOUT_RST}}};
         rdata  <= `GPDR_RD_IDLE;
         hv_sel <= `GPDR_HVSEL_OFF;
      end else begin
         p1     <= next_p1;
         p2     <= next_p2;
         rdata  <= next_rdata;
         hv_sel <= next_hv_sel;
      end
   end

   // pin drivers
   genvar g;
   generate
      for (g = 0; g < `GPDR_P1_PINS; g++) begin : g_p1
         assign p1_pin_oe_o[g] = p1.dir[g];
         assign p1_pin_o[g]    = p1.dout[g];
      end
      for (g = 0; g < `GPDR_P2_PINS; g++) begin : g_p2
         assign p2_pin_oe_o[g] = p2.dir[g];
         assign p2_pin_o[g]    = p2.dout[g];
      end
   endgenerate

   assign rdata_o           = rdata;
   assign hv_diag_wr_en_o   = p2.dir[`GPDR_P2_IDX5];
   assign hv_diag_wr_data_o = p2.dout[`GPDR_P2_IDX5];
   assign hv_readback_en_o  = !p2.dir[`GPDR_P2_IDX4];
   assign hv_readback_sel_o = hv_sel;

   // checks
   logic wr_p1;
   logic wr_p2;
   logic rd_p1;
   logic rd_p2;

   assign wr_p1 = wr_i && (addr_i == `GPDR_P1_ADDR);
   assign wr_p2 = wr_i && (addr_i == `GPDR_P2_ADDR);
   assign rd_p1 = rd_i && (addr_i == `GPDR_P1_ADDR);
   assign rd_p2 = rd_i && (addr_i == `GPDR_P2_ADDR);

   property p_p1_dir;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_p1 |=> p1_pin_oe_o == $past({wdata_i[`GPDR_P1_DIR1], wdata_i[`GPDR_P1_DIR0]});
   endproperty
   a_p1_dir: assert property (p_p1_dir)
      else $error("port 1 direction does not follow write");

   property p_p1_out;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_p1 ##1 !wr_p1 [*2]
      |-> p1_pin_o == $past({wdata_i[`GPDR_P1_DOUT1], wdata_i[`GPDR_P1_DOUT0]}, 2);
   endproperty
   a_p1_out: assert property (p_p1_out)
      else $error("port 1 output level lost after write");

   property p_p1_in;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_p1 |=> rdata_o[`GPDR_P1_DIN1:`GPDR_P1_DIN0] == $past(sync_lvl[1:0]);
   endproperty
   a_p1_in: assert property (p_p1_in)
      else $error("port 1 input bits do not show pin levels");

   property p_p2_dir;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_p2 |=> p2_pin_oe_o == $past({wdata_i[`GPDR_P2_DIR6], wdata_i[`GPDR_P2_DIR5],
         wdata_i[`GPDR_P2_DIR4], wdata_i[`GPDR_P2_DIR1], wdata_i[`GPDR_P2_DIR0]});
   endproperty
   a_p2_dir: assert property (p_p2_dir)
      else $error("port 2 direction does not follow write");

   property p_p2_out;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_p2 |=> p2_pin_o == $past({wdata_i[`GPDR_P2_DOUT6], wdata_i[`GPDR_P2_DOUT5],
         1'b0, wdata_i[`GPDR_P2_DOUT1], wdata_i[`GPDR_P2_DOUT0]});
   endproperty
   a_p2_out: assert property (p_p2_out)
      else $error("port 2 output levels wrong after write");

   property p_p2_in;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_p2 && !hv_active |=> {rdata_o[`GPDR_P2_DIN6:`GPDR_P2_DIN4],
         rdata_o[`GPDR_P2_DIN1:`GPDR_P2_DIN0]} == $past(p2_pin_i, 3);
   endproperty
   a_p2_in: assert property (p_p2_in)
      else $error("port 2 input bits do not show synchronised pins");

   property p_hv_wr;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_p2 |=> hv_diag_wr_en_o == $past(wdata_i[`GPDR_P2_DIR5])
         && hv_diag_wr_data_o == $past(wdata_i[`GPDR_P2_DOUT5]);
   endproperty
   a_hv_wr: assert property (p_hv_wr)
      else $error("diagnostic write path does not track pin 2.5");

   property p_hv_rd;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_p2 && hv_active |=> rdata_o[`GPDR_P2_DIN4] == $past(hv_readback_i, 3);
   endproperty
   a_hv_rd: assert property (p_hv_rd)
      else $error("pin 2.4 input bit misses high-voltage readback");

   property p_hv_sel;
      @(posedge clock_i) disable iff (!rst_n_i)
      $past(rst_n_i) |-> hv_readback_sel_o
         == (hv_readback_en_o ? $past(hv_cfg_sel_i) : `GPDR_HVSEL_OFF);
   endproperty
   a_hv_sel: assert property (p_hv_sel)
      else $error("readback selection does not follow the field");

   property p_rsv_zero;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_p1 |=> (rdata_o & `GPDR_P1_RSV) == `GPDR_RD_IDLE;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("reserved port 1 bits read nonzero");

   property p_rsv_zero_p2;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_p2 |=> (rdata_o & `GPDR_P2_RSV) == `GPDR_RD_IDLE;
   endproperty
   a_rsv_zero_p2: assert property (p_rsv_zero_p2)
      else $error("reserved port 2 bits read nonzero");

   property p_rd_unmapped;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_i && !rd_p1 && !rd_p2 |=> rdata_o == `GPDR_RD_IDLE;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped)
      else $error("unmapped read returns nonzero");

   property p_sync_delay;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_p1 |=> rdata_o[`GPDR_P1_DIN1:`GPDR_P1_DIN0] == $past(p1_pin_i, 3);
   endproperty
   a_sync_delay: assert property (p_sync_delay)
      else $error("port 1 pin level not two flops late");

   property p_rd_idle;
      @(posedge clock_i) disable iff (!rst_n_i)
      !rd_i |=> rdata_o == `GPDR_RD_IDLE;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data stands outside its cycle");

   c_p1_write: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      wr_p1 ##1 p1_pin_oe_o != '0);
   c_p2_read: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      wr_p2 ##1 rd_p2);
   c_hv_rdbk: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      rd_p2 && hv_active);
   c_hv_wr: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      hv_diag_wr_en_o && hv_diag_wr_data_o);

endmodule : gpdr_port_data

`default_nettype wire

//--- src/gpdr_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpdr_cfg.svh"

module gpdr_sync
   import gpdr_pkg::*;
#(
   parameter int WIDTH = `GPDR_SYNC_W
) (
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   // levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   // two flops, first one read only by the second
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
      end
   end

   assign sync_o = stage2;

endmodule : gpdr_sync

`default_nettype wire

//--- tb/gpdr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module gpdr_pin_model
   import gpdr_pkg::*;
(
   // levels driven by the outside world
   input  wire logic [1:0] p1_ext_i,
   input  wire logic [4:0] p2_ext_i,
   input  wire logic       hv_ext_i,
   // device drivers
   input  wire logic [1:0] p1_out_i,
   input  wire logic [1:0] p1_oe_i,
   input  wire logic [4:0] p2_out_i,
   input  wire logic [4:0] p2_oe_i,
   input  wire logic       hv_wr_en_i,
   input  wire logic       hv_wr_data_i,
   // resolved wires
   output logic      [1:0] p1_wire_o,
   output logic      [4:0] p2_wire_o,
   output logic            hv_wire_o
);
   // the device wins where it drives, else the outside level shows
   assign p1_wire_o = (p1_oe_i & p1_out_i) | (~p1_oe_i & p1_ext_i);
   assign p2_wire_o = (p2_oe_i & p2_out_i) | (~p2_oe_i & p2_ext_i);
   // a diagnostic write loops back onto the high-voltage readback
   assign hv_wire_o = hv_wr_en_i ? hv_wr_data_i : hv_ext_i;
endmodule : gpdr_pin_model

`default_nettype wire

//--- tb/gpio_port1_port2_data_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpdr_cfg.svh"

module gpio_port1_port2_data_regs_bench;
   import gpdr_pkg::*;
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, rdata_o, m1 = 32'h0, m2 = 32'h0, d, q, e;
   logic        wr_i = 1'b0, rd_i = 1'b0, hv_ext = 1'b0, hv_wire;
   logic [1:0]  p1_ext = 2'h0, p1_wire, p1_pin_o, p1_pin_oe_o;
   logic [4:0]  p2_ext = 5'h0, p2_wire, p2_pin_o, p2_pin_oe_o;
   logic [2:0]  hv_sel = 3'h0, hv_readback_sel_o;
   logic        hv_diag_wr_en_o, hv_diag_wr_data_o, hv_readback_en_o;
   int          n_fail = 0, tests_run = 0;

   always #2.5 clock_i = ~clock_i;

   gpdr_port_data dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .p1_pin_i(p1_wire), .p1_pin_o(p1_pin_o),
      .p1_pin_oe_o(p1_pin_oe_o), .p2_pin_i(p2_wire), .p2_pin_o(p2_pin_o),
      .p2_pin_oe_o(p2_pin_oe_o), .hv_cfg_sel_i(hv_sel), .hv_readback_i(hv_wire),
      .hv_diag_wr_en_o(hv_diag_wr_en_o), .hv_diag_wr_data_o(hv_diag_wr_data_o),
      .hv_readback_en_o(hv_readback_en_o), .hv_readback_sel_o(hv_readback_sel_o));

   gpdr_pin_model u_pins (.p1_ext_i(p1_ext), .p2_ext_i(p2_ext), .hv_ext_i(hv_ext),
      .p1_out_i(p1_pin_o), .p1_oe_i(p1_pin_oe_o), .p2_out_i(p2_pin_o), .p2_oe_i(p2_pin_oe_o),
      .hv_wr_en_i(hv_diag_wr_en_o), .hv_wr_data_i(hv_diag_wr_data_o), .p1_wire_o(p1_wire),
      .p2_wire_o(p2_wire), .hv_wire_o(hv_wire));

   // model of the stored words: direction and output fields only
   function automatic logic [4:0] dir2();
      return {m2[30], m2[29], m2[28], m2[25], m2[24]};
   endfunction : dir2
   function automatic logic [4:0] out2();
      return {m2[22], m2[21], 1'b0, m2[17], m2[16]};
   endfunction : out2
   function automatic logic [31:0] exp1();
      logic [1:0] w;
      w = (m1[25:24] & m1[17:16]) | (~m1[25:24] & p1_ext);
      return m1 | {30'h0, w};
   endfunction : exp1
   function automatic logic [31:0] exp2();
      logic [4:0] w;
      logic       hv;
      w = (dir2() & out2()) | (~dir2() & p2_ext);
      hv = m2[29] ? m2[21] : hv_ext;
      if (!m2[28] && hv_sel != 3'h0) w[2] = hv;
      return m2 | {25'h0, w[4], w[3], w[2], 2'h0, w[1], w[0]};
   endfunction : exp2

   task automatic chk_rd(input string what, input logic [31:0] ex, input logic [31:0] got);
      tests_run++;
      if (got !== ex) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, ex, got);
      end
   endtask : chk_rd
   task automatic chk_out(input string what, input logic [31:0] ex, input logic [31:0] got);
      tests_run++;
      if (got !== ex) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, ex, got);
      end
   endtask : chk_out

   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge clock_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clock_i);
      wr_i    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] v);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clock_i);
      rd_i   <= 1'b0;
      #1 v = rdata_o;
   endtask : rd

   task automatic check_out();
      chk_out("p1 drive", {28'h0, m1[17:16], m1[25:24]},
         {28'h0, p1_pin_o, p1_pin_oe_o});
      chk_out("p2 drive", {22'h0, out2(), dir2()},
         {22'h0, p2_pin_o, p2_pin_oe_o});
      chk_out("hv diag",
         {26'h0, m2[29], m2[21], !m2[28], m2[28] ? 3'h0 : hv_sel},
         {26'h0, hv_diag_wr_en_o, hv_diag_wr_data_o, hv_readback_en_o, hv_readback_sel_o});
   endtask : check_out
   task automatic check_all();
      repeat (4) @(posedge clock_i);
      #1 check_out();
      rd(`GPDR_P1_ADDR, q);
      chk_rd("port1 word", exp1(), q);
      rd(`GPDR_P2_ADDR, q);
      chk_rd("port2 word", exp2(), q);
   endtask : check_all

   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run

   initial begin
      #50000;
      n_fail++;
      complete_run();
   end

   initial begin
      void'($urandom(44776));
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      #1 check_out();
      check_all();
      for (int i = 0; i < 40; i++) begin
         @(posedge clock_i);
         p1_ext <= 2'($urandom);
         p2_ext <= 5'($urandom);
         hv_ext <= 1'($urandom);
         hv_sel <= 3'($urandom);
         d = $urandom & 32'h0303_0000;
         wr(`GPDR_P1_ADDR, d);
         m1 = d;
         d = $urandom & 32'h7363_0000;
         wr(`GPDR_P2_ADDR, d);
         m2 = d;
         check_all();
      end
      // unmapped address: write ignored, read returns zero
      wr(32'hffff0d34, 32'h0303_0000);
      rd(32'hffff0d38, q);
      chk_rd("unmapped", 32'h0, q);
      check_all();
      // a fresh pin level is not seen before the synchroniser settles
      wr(`GPDR_P1_ADDR, 32'h0);
      m1 = 32'h0;
      check_all();
      @(posedge clock_i);
      e = exp1();
      p1_ext <= ~p1_ext;
      rd(`GPDR_P1_ADDR, q);
      chk_rd("port1 sync lag", e, q);
      check_all();
      // reset in mid-run
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      hv_sel  <= 3'h0;
      repeat (2) @(posedge clock_i);
      m1 = 32'h0;
      m2 = 32'h0;
      #1 check_out();
      @(posedge clock_i);
      rst_n_i <= 1'b1;
      check_all();
      complete_run();
   end
endmodule : gpio_port1_port2_data_regs_bench

`default_nettype wire
